// ---- rtl/io_port_access_unit.sv ----
// Port access unit: single and string port transfers over an external bus.
// Notes on behaviour
// - 64K byte ports, addresses 0 to FFFF.
// - Moves 8, 16 or 32 bits per access.
// - Aligned halfword or word: one bus cycle.
// - Access that crosses a word boundary uses a second bus cycle.
// - Parity errors on port cycles are reported.
// - Memory-mapped side effects may repeat on retry.
// - Page cache disable suppresses caching.
// - Single port instructions make only port cycles; string ones add memory cycles.
// - Single transfer uses accumulator, immediate or index.
// - String uses segment plus source or destination.
// - Repeat steps index per item by direction.
// - Memory select high memory, low port.
`timescale 1ns/10ps
module io_port_access_unit (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic bus_strobe,
  output logic mem_io_sel,
  output logic bus_write,
  output logic [31:0] bus_addr,
  output logic [3:0] bus_lanes,
  output logic [31:0] bus_wdata,
  output logic cache_ok,
  input wire logic [31:0] bus_rdata,
  input wire logic bus_done,
  input wire logic bus_parity_err,
  input wire logic cache_enable_input_n
);

  // ****************************************
  // Synchronisers for pins from the far side
  // ****************************************
  logic [2:0] sy1_r, sy2_r;
  // Both stages reset to the idle pin levels, so no false handshake follows reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sy1_r <= 3'h4;
      sy2_r <= 3'h4;
    end else begin
      sy1_r <= {cache_enable_input_n, bus_parity_err, bus_done};
      sy2_r <= sy1_r;
    end
  end
  logic done_s, perr_s, cache_en_n_s;
  assign {cache_en_n_s, perr_s, done_s} = sy2_r;

  // ****************************************
  // State
  // ****************************************
  io_port_pkg::state_type st_r, st_nxt;
  logic [9:0] ctrl_r, ctrl_nxt;
  logic [15:0] port_r, port_nxt;
  logic [31:0] acc_r, acc_nxt, src_r, src_nxt, dst_r, dst_nxt;
  logic [31:0] dseg_r, dseg_nxt, eseg_r, eseg_nxt, cnt_r, cnt_nxt;
  logic [31:0] mema_r, mema_nxt, memd_r, memd_nxt, data_r, data_nxt;
  logic [3:0] done_lanes_r, done_lanes_nxt;
  logic busy_r, busy_nxt, perr_r, perr_nxt, rsv_r, rsv_nxt;
  io_port_pkg::bus_req_type req_r, req_nxt;
  logic strobe_r, strobe_nxt;
  logic [31:0] prdata_nxt;
  logic pready_nxt, pslverr_nxt;
  logic [1:0] wait_r, wait_nxt;

  logic [1:0] sz;
  logic [2:0] nbytes;
  logic [3:0] need, cyc_lanes;
  logic [17:0] span;
  logic [31:0] step, item_addr;
  always_comb begin
    sz = ctrl_r[io_port_pkg::SZ_LSB +: 2];
    nbytes = (sz == io_port_pkg::SZ_32) ? 3'h4 : (sz == io_port_pkg::SZ_16) ? 3'h2 : 3'h1;
    // Byte lanes within the word of the first addressed port; bits four and up wrap to a next word.
    span = (18'h1 << nbytes) - 18'h1;
    span = span << port_r[1:0];
    need = span[3:0];
    step = {29'h0, nbytes};
    item_addr = ctrl_r[io_port_pkg::DIR_OUT_BIT] ? dseg_r + src_r : eseg_r + dst_r;
  end

  // Lanes of this bus cycle: first word, then the carry word; never a byte twice.
  logic second;
  always_comb begin
    second = (done_lanes_r == need) && (span[7:4] != 4'h0);
    cyc_lanes = second ? span[7:4] : need;
  end

  logic acc_ph, wr;
  assign acc_ph = psel && penable;
  // Writes land at the edge where the master sees pready high and still holds the request.
  assign wr = acc_ph && pwrite && pready;

  always_comb begin
    st_nxt = st_r;
    ctrl_nxt = ctrl_r;
    port_nxt = port_r;
    acc_nxt = acc_r;
    src_nxt = src_r;
    dst_nxt = dst_r;
    dseg_nxt = dseg_r;
    eseg_nxt = eseg_r;
    cnt_nxt = cnt_r;
    mema_nxt = mema_r;
    memd_nxt = memd_r;
    data_nxt = data_r;
    done_lanes_nxt = done_lanes_r;
    busy_nxt = busy_r;
    perr_nxt = perr_r;
    rsv_nxt = rsv_r;
    req_nxt = req_r;
    strobe_nxt = 1'b0;
    wait_nxt = wait_r;
    prdata_nxt = prdata;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    // ****************************************
    // APB slave: one wait state, answer in access phase.
    // ****************************************
    if (acc_ph && !pready) begin
      pready_nxt = 1'b1;
      prdata_nxt = io_port_pkg::SLVERR_RD;
      if (paddr == io_port_pkg::CTRL_OFF) begin
        prdata_nxt = {22'h0, ctrl_r};
      end else if (paddr == io_port_pkg::PORT_OFF) begin
        prdata_nxt = {16'h0, port_r};
      end else if (paddr == io_port_pkg::ACC_OFF) begin
        prdata_nxt = acc_r;
      end else if (paddr == io_port_pkg::SRC_OFF) begin
        prdata_nxt = src_r;
      end else if (paddr == io_port_pkg::DST_OFF) begin
        prdata_nxt = dst_r;
      end else if (paddr == io_port_pkg::DSEG_OFF) begin
        prdata_nxt = dseg_r;
      end else if (paddr == io_port_pkg::ESEG_OFF) begin
        prdata_nxt = eseg_r;
      end else if (paddr == io_port_pkg::CNT_OFF) begin
        prdata_nxt = cnt_r;
      end else if (paddr == io_port_pkg::STAT_OFF) begin
        // A re-armed item reads as busy, so the gap between items never looks finished.
        prdata_nxt = {29'h0, rsv_r, perr_r,
                      busy_r || ctrl_r[io_port_pkg::GO_BIT] || ctrl_r[io_port_pkg::MEMGO_BIT]};
      end else if (paddr == io_port_pkg::MEMA_OFF) begin
        prdata_nxt = mema_r;
      end else if (paddr == io_port_pkg::MEMD_OFF) begin
        prdata_nxt = memd_r;
      end else begin
        pslverr_nxt = 1'b1;
      end
    end
    // Writes to state registers are ignored while a transfer runs.
    if (wr && !busy_r) begin
      if (paddr == io_port_pkg::CTRL_OFF) begin
        ctrl_nxt = pwdata[9:0];
      end else if (paddr == io_port_pkg::PORT_OFF) begin
        port_nxt = pwdata[15:0];
      end else if (paddr == io_port_pkg::ACC_OFF) begin
        acc_nxt = pwdata;
      end else if (paddr == io_port_pkg::SRC_OFF) begin
        src_nxt = pwdata;
      end else if (paddr == io_port_pkg::DST_OFF) begin
        dst_nxt = pwdata;
      end else if (paddr == io_port_pkg::DSEG_OFF) begin
        dseg_nxt = pwdata;
      end else if (paddr == io_port_pkg::ESEG_OFF) begin
        eseg_nxt = pwdata;
      end else if (paddr == io_port_pkg::CNT_OFF) begin
        cnt_nxt = pwdata;
      end else if (paddr == io_port_pkg::MEMA_OFF) begin
        mema_nxt = pwdata;
      end else if (paddr == io_port_pkg::MEMD_OFF) begin
        memd_nxt = pwdata;
      end
    end
    // Status error flags clear on a write of one; a fresh event wins.
    if (wr && paddr == io_port_pkg::STAT_OFF) begin
      if (pwdata[1]) perr_nxt = 1'b0;
      if (pwdata[2]) rsv_nxt = 1'b0;
    end
    // ****************************************
    // Transfer engine
    // ****************************************
    case (st_r)
      io_port_pkg::ST_IDLE: begin
        if (ctrl_r[io_port_pkg::GO_BIT]) begin
          ctrl_nxt[io_port_pkg::GO_BIT] = 1'b0;
          busy_nxt = 1'b1;
          done_lanes_nxt = 4'h0;
          if (port_r >= io_port_pkg::RSV_LO && port_r <= io_port_pkg::RSV_HI) rsv_nxt = 1'b1;
          if (ctrl_r[io_port_pkg::STRING_BIT] && ctrl_r[io_port_pkg::REPEAT_BIT] &&
              cnt_r == 32'h0) begin
            busy_nxt = 1'b0;
          end else if (ctrl_r[io_port_pkg::STRING_BIT] && ctrl_r[io_port_pkg::DIR_OUT_BIT]) begin
            st_nxt = io_port_pkg::ST_MEMRD;
          end else begin
            data_nxt = acc_r;
            st_nxt = io_port_pkg::ST_BUS;
          end
        end else if (ctrl_r[io_port_pkg::MEMGO_BIT]) begin
          ctrl_nxt[io_port_pkg::MEMGO_BIT] = 1'b0;
          busy_nxt = 1'b1;
          st_nxt = io_port_pkg::ST_MEMORY_MAPPED_PORT_ACCESS;
        end
      end
      io_port_pkg::ST_MEMRD, io_port_pkg::ST_MEMWR, io_port_pkg::ST_MEMORY_MAPPED_PORT_ACCESS: begin
        // Memory cycle; cacheable only if neither page flag nor pin blocks it.
        req_nxt.mem_not_port = 1'b1;
        req_nxt.write = (st_r != io_port_pkg::ST_MEMRD) &&
                        !(st_r == io_port_pkg::ST_MEMORY_MAPPED_PORT_ACCESS && !ctrl_r[io_port_pkg::MEMWR_BIT]);
        req_nxt.addr = (st_r == io_port_pkg::ST_MEMORY_MAPPED_PORT_ACCESS) ? mema_r : item_addr;
        req_nxt.lanes = 4'hF;
        req_nxt.data = (st_r == io_port_pkg::ST_MEMORY_MAPPED_PORT_ACCESS) ? memd_r : data_r;
        req_nxt.cache_ok = !ctrl_r[io_port_pkg::PAGE_CACHE_DISABLE_BIT] && !cache_en_n_s;
        if (wait_r == 2'h0) begin
          strobe_nxt = 1'b1;
          wait_nxt = 2'h1;
        end else if (wait_r == 2'h1 && !done_s) begin
          wait_nxt = 2'h2;
        end else if (wait_r == 2'h2 && done_s) begin
          wait_nxt = 2'h3;
          if (!req_r.write) begin
            if (st_r == io_port_pkg::ST_MEMORY_MAPPED_PORT_ACCESS) memd_nxt = bus_rdata;
            else data_nxt = bus_rdata;
          end
        end else if (wait_r == 2'h3 && !done_s) begin
          wait_nxt = 2'h0;
          if (st_r == io_port_pkg::ST_MEMRD) begin
            st_nxt = io_port_pkg::ST_BUS;
          end else begin
            st_nxt = io_port_pkg::ST_IDLE;
            busy_nxt = 1'b0;
            if (st_r == io_port_pkg::ST_MEMWR) begin
              dst_nxt = ctrl_r[io_port_pkg::DIRECTION_FLAG_BIT] ? dst_r - step :
                        dst_r + step;
            end
          end
        end
      end
      io_port_pkg::ST_BUS: begin
        // Port cycle only: never a memory cycle, never cached.
        req_nxt.mem_not_port = 1'b0;
        req_nxt.write = ctrl_r[io_port_pkg::DIR_OUT_BIT];
        req_nxt.addr = {16'h0, port_r[15:2] + {13'h0, second}, 2'h0};
        req_nxt.lanes = cyc_lanes;
        req_nxt.data = second ? (data_r >> (8 * (4 - port_r[1:0])))
                              : (data_r << (8 * port_r[1:0]));
        req_nxt.cache_ok = 1'b0;
        if (wait_r == 2'h0) begin
          strobe_nxt = 1'b1;
          wait_nxt = 2'h1;
        end else if (wait_r == 2'h1 && !done_s) begin
          wait_nxt = 2'h2;
        end else if (wait_r == 2'h2 && done_s) begin
          wait_nxt = 2'h3;
          if (perr_s) perr_nxt = 1'b1;
          if (!req_r.write) begin
            if (second) begin
              data_nxt = data_r | (bus_rdata << (8 * (4 - port_r[1:0])));
            end else begin
              data_nxt = bus_rdata >> (8 * port_r[1:0]);
            end
          end
        end else if (wait_r == 2'h3 && !done_s) begin
          wait_nxt = 2'h0;
          // The first cycle is marked done only here, so it keeps its own lanes to the end.
          if (span[7:4] != 4'h0 && !second) begin
            done_lanes_nxt = cyc_lanes;
            st_nxt = io_port_pkg::ST_BUS;
          end else begin
            done_lanes_nxt = 4'h0;
            if (!ctrl_r[io_port_pkg::STRING_BIT]) begin
              if (!ctrl_r[io_port_pkg::DIR_OUT_BIT]) begin
                acc_nxt = (sz == io_port_pkg::SZ_32) ? data_r :
                          (sz == io_port_pkg::SZ_16) ? {acc_r[31:16], data_r[15:0]} :
                          {acc_r[31:8], data_r[7:0]};
              end
              st_nxt = io_port_pkg::ST_IDLE;
              busy_nxt = 1'b0;
            end else if (ctrl_r[io_port_pkg::DIR_OUT_BIT]) begin
              src_nxt = ctrl_r[io_port_pkg::DIRECTION_FLAG_BIT] ? src_r - step :
                        src_r + step;
              st_nxt = io_port_pkg::ST_IDLE;
              busy_nxt = 1'b0;
            end else begin
              data_nxt = (sz == io_port_pkg::SZ_32) ? data_r :
                         (sz == io_port_pkg::SZ_16) ? {16'h0, data_r[15:0]} :
                         {24'h0, data_r[7:0]};
              st_nxt = io_port_pkg::ST_MEMWR;
            end
            if (ctrl_r[io_port_pkg::STRING_BIT] && ctrl_r[io_port_pkg::REPEAT_BIT]) begin
              cnt_nxt = cnt_r - 32'h1;
              if (cnt_r != 32'h1 && ctrl_r[io_port_pkg::DIR_OUT_BIT]) begin
                ctrl_nxt[io_port_pkg::GO_BIT] = 1'b1;
              end
            end
          end
        end
      end
      default: st_nxt = io_port_pkg::ST_IDLE;
    endcase
    // Repeated input resumes the next item after its memory write.
    if (st_r == io_port_pkg::ST_MEMWR && st_nxt == io_port_pkg::ST_IDLE &&
        ctrl_r[io_port_pkg::REPEAT_BIT] && cnt_r != 32'h0) begin
      ctrl_nxt[io_port_pkg::GO_BIT] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= io_port_pkg::ST_IDLE;
      ctrl_r <= 10'h000;
      port_r <= 16'h0000;
      acc_r <= 32'h0000_0000;
      src_r <= 32'h0000_0000;
      dst_r <= 32'h0000_0000;
      dseg_r <= 32'h0000_0000;
      eseg_r <= 32'h0000_0000;
      cnt_r <= 32'h0000_0000;
      mema_r <= 32'h0000_0000;
      memd_r <= 32'h0000_0000;
      data_r <= 32'h0000_0000;
      done_lanes_r <= 4'h0;
      busy_r <= 1'b0;
      perr_r <= 1'b0;
      rsv_r <= 1'b0;
      req_r <= '0;
      strobe_r <= 1'b0;
      wait_r <= 2'h0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      st_r <= st_nxt;
      ctrl_r <= ctrl_nxt;
      port_r <= port_nxt;
      acc_r <= acc_nxt;
      src_r <= src_nxt;
      dst_r <= dst_nxt;
      dseg_r <= dseg_nxt;
      eseg_r <= eseg_nxt;
      cnt_r <= cnt_nxt;
      mema_r <= mema_nxt;
      memd_r <= memd_nxt;
      data_r <= data_nxt;
      done_lanes_r <= done_lanes_nxt;
      busy_r <= busy_nxt;
      perr_r <= perr_nxt;
      rsv_r <= rsv_nxt;
      req_r <= req_nxt;
      strobe_r <= strobe_nxt;
      wait_r <= wait_nxt;
      prdata <= prdata_nxt;
      pready <= pready_nxt;
      pslverr <= pslverr_nxt;
    end
  end

  assign bus_strobe = strobe_r;
  assign mem_io_sel = req_r.mem_not_port;
  assign bus_write = req_r.write;
  assign bus_addr = req_r.addr;
  assign bus_lanes = req_r.lanes;
  assign bus_wdata = req_r.data;
  assign cache_ok = req_r.cache_ok;

  // ****************************************
  // Assertions
  // ****************************************
  port_no_cache_a: assert property (@(posedge pclk) disable iff (!presetn)
    bus_strobe && !mem_io_sel |-> !cache_ok) else $error("port cycle marked cacheable");
  page_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    bus_strobe && ctrl_r[io_port_pkg::PAGE_CACHE_DISABLE_BIT] |-> !cache_ok)
    else $error("page flag ignored");
  aligned_once_a: assert property (@(posedge pclk) disable iff (!presetn)
    bus_strobe && !mem_io_sel && span[7:4] == 4'h0 |-> bus_lanes == need)
    else $error("aligned access not single cycle");
  lanes_ok_a: assert property (@(posedge pclk) disable iff (!presetn)
    bus_strobe && !mem_io_sel |-> bus_lanes != 4'h0) else $error("empty lane set");
  pready_one_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready) else $error("pready held");
  in_only_port_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == io_port_pkg::ST_BUS && bus_strobe |-> !mem_io_sel) else $error("select wrong");
  perr_seen_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == io_port_pkg::ST_BUS && wait_r == 2'h2 && done_s && perr_s |=> perr_r)
    else $error("parity error lost");
  index_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == io_port_pkg::ST_MEMWR && st_nxt == io_port_pkg::ST_IDLE |=>
    dst_r != $past(dst_r)) else $error("index not stepped");
  c_split: cover property (@(posedge pclk) bus_strobe && !mem_io_sel && second);
  c_strin: cover property (@(posedge pclk) st_r == io_port_pkg::ST_MEMWR && bus_strobe);
  c_memory_mapped_port_access: cover property (@(posedge pclk) st_r == io_port_pkg::ST_MEMORY_MAPPED_PORT_ACCESS && bus_strobe);

endmodule

// ---- rtl/io_port_pkg.sv ----
// Package of constants and types for the port access unit.
package io_port_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] PORT_OFF = 8'h04;
  localparam logic [7:0] ACC_OFF = 8'h08;
  localparam logic [7:0] SRC_OFF = 8'h0C;
  localparam logic [7:0] DST_OFF = 8'h10;
  localparam logic [7:0] DSEG_OFF = 8'h14;
  localparam logic [7:0] ESEG_OFF = 8'h18;
  localparam logic [7:0] CNT_OFF = 8'h1C;
  localparam logic [7:0] STAT_OFF = 8'h20;
  localparam logic [7:0] MEMA_OFF = 8'h24;
  localparam logic [7:0] MEMD_OFF = 8'h28;

  // Control fields.
  localparam int GO_BIT = 0;
  localparam int DIR_OUT_BIT = 1;
  localparam int STRING_BIT = 2;
  localparam int REPEAT_BIT = 3;
  localparam int DIRECTION_FLAG_BIT = 4;
  localparam int SZ_LSB = 5;
  localparam int PAGE_CACHE_DISABLE_BIT = 7;
  localparam int MEMGO_BIT = 8;
  localparam int MEMWR_BIT = 9;

  localparam logic [1:0] SZ_8 = 2'h0;
  localparam logic [1:0] SZ_16 = 2'h1;
  localparam logic [1:0] SZ_32 = 2'h2;

  localparam logic [15:0] PORT_TOP = 16'hFFFF;
  localparam logic [15:0] RSV_LO = 16'h00F8;
  localparam logic [15:0] RSV_HI = 16'h00FF;

  localparam logic [31:0] SLVERR_RD = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_MEMRD = 3'b001,
    ST_BUS = 3'b010,
    ST_MEMWR = 3'b011,
    ST_MEMORY_MAPPED_PORT_ACCESS = 3'b100
  } state_type;

  // One external bus cycle request.
  typedef struct packed {
    logic mem_not_port;
    logic write;
    logic [31:0] addr;
    logic [3:0] lanes;
    logic [31:0] data;
    logic cache_ok;
  } bus_req_type;

endpackage

// ---- tb/port_peripheral_model.sv ----
// Behavioural peripherals and memory on the far side of the external bus.
`timescale 1ns/10ps
module port_peripheral_model (
  input wire logic pclk,
  input wire logic bus_strobe,
  input wire logic mem_io_sel,
  input wire logic bus_write,
  input wire logic [31:0] bus_addr,
  input wire logic [3:0] bus_lanes,
  input wire logic [31:0] bus_wdata,
  input wire logic [3:0] delay,
  input wire logic parity_on,
  output logic [31:0] bus_rdata,
  output logic bus_done,
  output logic bus_parity_err
);
  logic [31:0] store [logic [30:0]];
  logic [31:0] word;
  logic [30:0] key;

  // ****************************************
  // Four-phase answer
  // ****************************************
  // Once done falls the read lines carry the inverse, so stale data never looks valid.
  initial begin
    bus_done = 1'b0;
    bus_rdata = 32'h5A5A_5A5A;
    bus_parity_err = 1'b0;
    forever begin
      @(posedge pclk);
      if (bus_strobe === 1'b1) begin
        key = {mem_io_sel, bus_addr[31:2]};
        word = store.exists(key) ? store[key] : 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
          if (bus_write && bus_lanes[i]) begin
            word[8*i +: 8] = bus_wdata[8*i +: 8];
          end
        end
        store[key] = word;
        repeat (delay) @(posedge pclk);
        bus_rdata <= word;
        bus_parity_err <= parity_on;
        bus_done <= 1'b1;
        repeat (6) @(posedge pclk);
        bus_done <= 1'b0;
        bus_rdata <= ~word;
        bus_parity_err <= 1'b0;
      end
    end
  end
endmodule

// ---- tb/test_io_port_access_unit.sv ----
// Self-checking bench for the port access unit.
`timescale 1ns/10ps
module test_io_port_access_unit;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, bus_addr, bus_wdata, bus_rdata, rd;
  logic pready, pslverr, bus_strobe, mem_io_sel, bus_write, cache_ok, bus_done, bus_parity_err;
  logic [3:0] bus_lanes;
  logic cache_enable_input_n = 1'b1;
  logic [3:0] delay = 4'h0;
  logic parity_on = 1'b0;
  logic [31:0] q_addr[$];
  logic [3:0] q_lanes[$];
  logic q_mem[$];
  logic q_cache[$];
  int fail_count = 0;
  int tests_run = 0;
  logic [15:0] ports [6] = '{16'h0010, 16'h0021, 16'h0023, 16'h0040, 16'h0046, 16'hFFFC};
  logic [1:0] sizes [6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2};

  always #50 pclk = ~pclk;

  io_port_access_unit dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus_strobe(bus_strobe), .mem_io_sel(mem_io_sel),
    .bus_write(bus_write), .bus_addr(bus_addr), .bus_lanes(bus_lanes),
    .bus_wdata(bus_wdata), .cache_ok(cache_ok), .bus_rdata(bus_rdata), .bus_done(bus_done),
    .bus_parity_err(bus_parity_err), .cache_enable_input_n(cache_enable_input_n));

  port_peripheral_model far (.pclk(pclk), .bus_strobe(bus_strobe), .mem_io_sel(mem_io_sel),
    .bus_write(bus_write), .bus_addr(bus_addr), .bus_lanes(bus_lanes),
    .bus_wdata(bus_wdata), .delay(delay), .parity_on(parity_on), .bus_rdata(bus_rdata),
    .bus_done(bus_done), .bus_parity_err(bus_parity_err));

  always @(posedge pclk) begin
    if (bus_strobe === 1'b1) begin
      q_addr.push_back(bus_addr);
      q_lanes.push_back(bus_lanes);
      q_mem.push_back(mem_io_sel);
      q_cache.push_back(cache_ok);
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    rd = prdata;
    check("pready", {31'h0, pready}, 32'h0000_0001);
    check("pslverr", {31'h0, pslverr}, {31'h0, a > 8'h28});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(what, rd, exp);
  endtask

  task automatic run(input logic [31:0] ctrl);
    int n;
    q_addr.delete();
    q_lanes.delete();
    q_mem.delete();
    q_cache.delete();
    apb(1'b1, io_port_pkg::CTRL_OFF, ctrl);
    n = 0;
    rd = 32'h0000_0001;
    while (rd[0] !== 1'b0 && n < 300) begin
      apb(1'b0, io_port_pkg::STAT_OFF, 32'h0000_0000);
      n++;
    end
    check("idle", {31'h0, rd[0]}, 32'h0000_0000);
  endtask

  function automatic logic [31:0] ctl(input logic o, input logic s, input logic r,
      input logic d, input logic [1:0] sz, input logic p, input logic m, input logic mw);
    ctl = 32'h0000_0000;
    ctl[io_port_pkg::GO_BIT] = !m;
    ctl[io_port_pkg::DIR_OUT_BIT] = o;
    ctl[io_port_pkg::STRING_BIT] = s;
    ctl[io_port_pkg::REPEAT_BIT] = r;
    ctl[io_port_pkg::DIRECTION_FLAG_BIT] = d;
    ctl[io_port_pkg::SZ_LSB +: 2] = sz;
    ctl[io_port_pkg::PAGE_CACHE_DISABLE_BIT] = p;
    ctl[io_port_pkg::MEMGO_BIT] = m;
    ctl[io_port_pkg::MEMWR_BIT] = mw;
  endfunction

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    logic [7:0] m;
    logic [31:0] base, mask;
    int nb, nmem;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("status", io_port_pkg::STAT_OFF, 32'h0000_0000);
    rd_chk("unmapped", 8'h30, 32'h0000_0000);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      delay = i[0] ? 4'h5 : 4'h0;
      nb = 1 << sizes[i];
      m = 8'((16'h1 << nb) - 1) << ports[i][1:0];
      mask = (nb == 4) ? 32'hFFFF_FFFF : ((32'h1 << (8 * nb)) - 1);
      base = {16'h0000, ports[i][15:2], 2'b00};
      apb(1'b1, io_port_pkg::PORT_OFF, {16'h0000, ports[i]});
      apb(1'b1, io_port_pkg::ACC_OFF, 32'hA1B2_C3D4);
      run(ctl(1'b1, 1'b0, 1'b0, 1'b0, sizes[i], 1'b0, 1'b0, 1'b0));
      check("cycles", 32'(q_addr.size()), (m[7:4] != 4'h0) ? 32'h2 : 32'h1);
      foreach (q_addr[j]) begin
        check("memory select", {31'h0, q_mem[j]}, 32'h0000_0000);
        check("address", {31'h0, q_addr[j] == base || q_addr[j] == base + 4}, 32'h1);
        check("lanes", {28'h0, q_lanes[j]}, {28'h0, (q_addr[j] == base) ? m[3:0] : m[7:4]});
      end
      apb(1'b1, io_port_pkg::ACC_OFF, 32'h0000_0000);
      run(ctl(1'b0, 1'b0, 1'b0, 1'b0, sizes[i], 1'b0, 1'b0, 1'b0));
      rd_chk("accumulator", io_port_pkg::ACC_OFF, 32'hA1B2_C3D4 & mask);
    end
    $display("test single done");
    parity_on = 1'b1;
    apb(1'b1, io_port_pkg::PORT_OFF, 32'h0000_00F8);
    run(ctl(1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0));
    parity_on = 1'b0;
    rd_chk("flags", io_port_pkg::STAT_OFF, 32'h0000_0006);
    apb(1'b1, io_port_pkg::STAT_OFF, 32'h0000_0006);
    rd_chk("flags cleared", io_port_pkg::STAT_OFF, 32'h0000_0000);
    $display("test flags done");
    apb(1'b1, io_port_pkg::PORT_OFF, 32'h0000_0010);
    apb(1'b1, io_port_pkg::ESEG_OFF, 32'h0000_2000);
    apb(1'b1, io_port_pkg::DST_OFF, 32'h0000_0200);
    apb(1'b1, io_port_pkg::CNT_OFF, 32'h0000_0003);
    cache_enable_input_n <= 1'b0;
    run(ctl(1'b0, 1'b1, 1'b1, 1'b1, 2'h1, 1'b0, 1'b0, 1'b0));
    cache_enable_input_n <= 1'b1;
    nmem = 0;
    foreach (q_mem[j]) nmem += q_mem[j];
    foreach (q_mem[j]) check("cache by kind", {31'h0, q_cache[j]}, {31'h0, q_mem[j]});
    check("memory cycles", 32'(nmem), 32'h3);
    check("port cycles", 32'(q_mem.size() - nmem), 32'h3);
    check("first item order", {31'h0, q_mem[0]}, 32'h0000_0000);
    rd_chk("destination", io_port_pkg::DST_OFF, 32'h0000_01FA);
    rd_chk("count", io_port_pkg::CNT_OFF, 32'h0000_0000);
    $display("test string input done");
    apb(1'b1, io_port_pkg::MEMA_OFF, 32'h0000_1300);
    apb(1'b1, io_port_pkg::MEMD_OFF, 32'hCAFE_F00D);
    run(ctl(1'b0, 1'b0, 1'b0, 1'b0, 2'h2, 1'b1, 1'b1, 1'b1));
    check("memory_mapped_port_access select", {31'h0, q_mem[0]}, 32'h0000_0001);
    check("page cache disable", {31'h0, q_cache[0]}, 32'h0000_0000);
    apb(1'b1, io_port_pkg::MEMD_OFF, 32'h0000_0000);
    run(ctl(1'b0, 1'b0, 1'b0, 1'b0, 2'h2, 1'b0, 1'b1, 1'b0));
    check("cache blocked", {31'h0, q_cache[0]}, 32'h0000_0000);
    rd_chk("memory_mapped_port_access data", io_port_pkg::MEMD_OFF, 32'hCAFE_F00D);
    $display("test memory_mapped_port_access done");
    delay = 4'h3;
    apb(1'b1, io_port_pkg::PORT_OFF, 32'h0000_0044);
    apb(1'b1, io_port_pkg::DSEG_OFF, 32'h0000_1000);
    apb(1'b1, io_port_pkg::SRC_OFF, 32'h0000_02FC);
    apb(1'b1, io_port_pkg::CNT_OFF, 32'h0000_0002);
    run(ctl(1'b1, 1'b1, 1'b1, 1'b0, 2'h2, 1'b0, 1'b0, 1'b0));
    check("read before write", {31'h0, q_mem[0]}, 32'h0000_0001);
    check("source address", q_addr[0], 32'h0000_12FC);
    check("items", 32'(q_addr.size()), 32'h4);
    rd_chk("source", io_port_pkg::SRC_OFF, 32'h0000_0304);
    apb(1'b1, io_port_pkg::ACC_OFF, 32'h0000_0000);
    run(ctl(1'b0, 1'b0, 1'b0, 1'b0, 2'h2, 1'b0, 1'b0, 1'b0));
    rd_chk("last item", io_port_pkg::ACC_OFF, 32'hCAFE_F00D);
    $display("test string output done");
    tally_and_finish();
  end

  // The whole sequence needs under a thousand cycles; the margin covers slow answers.
  initial begin
    repeat (40000) @(posedge pclk);
    fail_count++;
    tally_and_finish();
  end
endmodule
